/* dv/jtp_host.sv */
// Behavioural test host that clocks the serial test port through scans.
`timescale 1ns/10ps
module jtp_host (
    input wire logic mclk,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // The test clock is low for 5 cycles and high for 3, and stands low between calls.
    // Reading tdo just before the rise leaves room for its 3 cycle lag.
    task automatic step(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        repeat (5) @(posedge mclk);
        q = tdo;
        tck <= 1'b1;
        repeat (3) @(posedge mclk);
        tck <= 1'b0;
    endtask

    // Runs from Run-Test/Idle through one scan, least significant bit first, back to idle.
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        step(1'b1, 1'b0, q);
        if (ir) begin
            step(1'b1, 1'b0, q);
        end
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
endmodule // jtp_host

/* dv/testbench.sv */
// Self-checking bench for the test access port block.
`timescale 1ns/10ps
module testbench
    import jtp_pkg::*;
;
    localparam logic [31:0] ID_VALUE = 32'h1357_9bdf; // Arbitrary value.
    logic mclk = 1'b0, rstn = 1'b0, test_logic_reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, cr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    logic pready, pslverr, tdo, tdo_oe, err, tck, tms, tdi, o;
    logic cells_test_mode, outputs_disable, float_indicator;
    logic chain_capture, chain_shift, chain_si, restart_pulse, chain_update, oe_seen = 1'b0;
    logic [3:0] tap_state_code, instr_code;
    logic [4:0] chain_select;
    // Code in the top four bits, then test mode, output disable and float flags.
    logic [6:0] tbl [11] = '{7'h78, 7'h2c, 7'h3b, 7'h4e, 7'h20, 7'h08, 7'h30, 7'h40,
        7'h50, 7'h58, 7'h68};
    logic [6:0] ctbl [3] = '{7'h04, 7'h64, 7'h18};
    int errors = 0, checks_done = 0, cycles = 0, restarts = 0, updates = 0;

    always #5 mclk = ~mclk;

    jtp_tap DUT (
        .mclk(mclk), .rstn(rstn), .test_logic_reset_n(test_logic_reset_n),
        .tck(tck), .tms(tms), .tdi(tdi), .id_code_inputs(ID_VALUE),
        .chain_so(cr[0]), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tdo(tdo), .tdo_oe(tdo_oe), .tap_state_code(tap_state_code),
        .instr_code(instr_code), .chain_select(chain_select),
        .cells_test_mode(cells_test_mode), .outputs_disable(outputs_disable),
        .float_indicator(float_indicator), .chain_capture(chain_capture),
        .chain_shift(chain_shift), .chain_update(chain_update), .chain_si(chain_si),
        .restart_pulse(restart_pulse)
    );

    jtp_host host (.mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));

    // An eight-cell external chain stands in for the boundary cells.
    always @(posedge mclk) begin
        if (chain_capture === 1'b1) begin
            cr <= 8'ha5;
        end else if (chain_shift === 1'b1) begin
            cr <= {chain_si, cr[7:1]};
        end
        if (restart_pulse === 1'b1) begin
            restarts <= restarts + 1;
        end
        if (chain_update === 1'b1) begin
            updates <= updates + 1;
        end
        if (tdo_oe === 1'b1) begin
            oe_seen <= 1'b1;
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] r, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        test_logic_reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(tap_state_code, 4'hf);
        chk({instr_code, chain_select}, {JTP_IR_IDCODE, JTP_SEL_RESET});
        chk({cells_test_mode, outputs_disable, float_indicator}, 3'b000);
        apb(1'b0, JTP_REG_STATUS, 32'h0, rd, err);
        chk(rd, 32'h0000_03ef);
        apb(1'b0, JTP_REG_CTRL, 32'h0, rd, err);
        chk(rd, JTP_CTRL_RESET);
        apb(1'b0, 8'h0c, 32'h0, rd, err);
        chk(err, 1'b1);
        host.step(1'b0, 1'b0, o);
        // The state flop loads at the edge on which the step returns, so look one edge later.
        @(posedge mclk);
        chk(tap_state_code, 4'hc);
        host.scan(1'b0, 32, 32'h0, d);
        chk(d, ID_VALUE);
        chk({oe_seen, tdo_oe}, 2'b10);
        $display("test reset_and_id done");
        host.scan(1'b1, 4, {28'h0, JTP_IR_SCAN_SEL}, d);
        chk(d, 32'h1);
        chk(instr_code, JTP_IR_SCAN_SEL);
        host.scan(1'b0, 5, 32'h0, d);
        chk(d, {27'h0, JTP_SEL_CAPTURE});
        chk(chain_select, JTP_SEL_CHAIN0);
        foreach (tbl[i]) begin
            host.scan(1'b1, 4, {28'h0, tbl[i][6:3]}, d);
            chk({cells_test_mode, outputs_disable, float_indicator}, tbl[i][2:0]);
            host.scan(1'b0, 4, 32'hb, d);
            chk(d, 32'h6);
        end
        chk(restarts, 2);
        $display("test bypass_codes done");
        foreach (ctbl[i]) begin
            host.scan(1'b1, 4, {28'h0, ctbl[i][6:3]}, d);
            chk({cells_test_mode, outputs_disable, float_indicator}, ctbl[i][2:0]);
            host.scan(1'b0, 8, 32'h3c, d);
            chk(d, 32'ha5);
            chk(cr, 8'h3c);
        end
        chk(updates, 3);
        $display("test chain_path done");
        apb(1'b1, JTP_REG_CTRL, 32'h0, rd, err);
        repeat (3) @(posedge mclk);
        chk(outputs_disable, 1'b1);
        apb(1'b1, JTP_REG_STATUS, 32'hffff_ffff, rd, err);
        apb(1'b0, JTP_REG_STATUS, 32'h0, rd, err);
        chk(rd, 32'h0000_003c);
        apb(1'b0, JTP_REG_ID, 32'h0, rd, err);
        chk(rd, ID_VALUE);
        chk(err, 1'b0);
        apb(1'b1, JTP_REG_CTRL, 32'h1, rd, err);
        $display("test registers done");
        host.step(1'b1, 1'b0, o);
        test_logic_reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({tap_state_code, instr_code, 3'b0, chain_select}, 16'hfe03);
        test_logic_reset_n <= 1'b1;
        host.step(1'b0, 1'b0, o);
        host.scan(1'b1, 4, 32'hf, d);
        repeat (5) host.step(1'b1, 1'b0, o);
        chk({tap_state_code, instr_code}, 8'hfe);
        $display("test resets done");
        results();
    end
endmodule // testbench

/* logic/jtp_apb_regs.sv */
// APB slave holding the control word and reporting the test port status.
`timescale 1ns/10ps
module jtp_apb_regs
    import jtp_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] stat_state,
    input wire logic [3:0] stat_instr,
    input wire logic [4:0] stat_chain,
    input wire logic stat_float,
    input wire logic [31:0] stat_id,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic bus_output_enable
);
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [31:0] ctrl;
    } jtp_apb_type;

    jtp_apb_type st_q;
    jtp_apb_type st_d;
    logic setup;
    logic mapped;
    logic [31:0] status;

    always_comb begin
        st_d = st_q;
        status = '0;
        status[JTP_ST_STATE_LSB +: 4] = stat_state;
        status[JTP_ST_INSTR_LSB +: 4] = stat_instr;
        status[JTP_ST_CHAIN_LSB +: 5] = stat_chain;
        status[JTP_ST_FLOAT_BIT] = stat_float;
        // The answer is prepared in the setup cycle, so every access takes one wait-free cycle.
        setup = psel && !penable && !st_q.pready;
        mapped = (paddr == JTP_REG_CTRL) || (paddr == JTP_REG_STATUS) || (paddr == JTP_REG_ID);
        st_d.pready = setup;
        if (setup) begin
            st_d.pslverr = !mapped;
            st_d.prdata = '0;
            if (!pwrite) begin
                unique case (paddr)
                    JTP_REG_CTRL: st_d.prdata = st_q.ctrl;
                    JTP_REG_STATUS: st_d.prdata = status;
                    JTP_REG_ID: st_d.prdata = stat_id;
                    default: st_d.prdata = '0;
                endcase
            end
        end
        if (psel && penable && st_q.pready && pwrite && (paddr == JTP_REG_CTRL)) begin
            st_d.ctrl = '0;
            st_d.ctrl[JTP_CTRL_BUS_OE_BIT] = pwdata[JTP_CTRL_BUS_OE_BIT];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '{pready: 1'b0, pslverr: 1'b0, prdata: '0, ctrl: JTP_CTRL_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign bus_output_enable = st_q.ctrl[JTP_CTRL_BUS_OE_BIT];
endmodule // jtp_apb_regs

/* logic/jtp_pkg.sv */
// Constants, state and path types and helper functions for the test access port block.
// Functional notes
// - State number shown on 4-bit output continuously.
// - Test reset forces Test-Logic-Reset without clocks.
// - Reset leaves all scan cells transparent.
// - Reset makes identification instruction current.
// - Inputs sampled on rising, output on falling.
// - Instruction register 4 bits, captures 0001.
// - EXTEST: chain in path, cells test mode.
// - Chain select: 5 bits, captures 10000.
// - Reset selects scan chain 3.
// - INTEST: chain in path, cells test mode.
// - IDCODE: 32-bit register loads identification inputs.
// - BYPASS: one bit, captures 0, no update.
// - Unassigned codes behave exactly as bypass.
// - CLAMP: bypass path, outputs from chain.
// - Float-all: outputs float, indicator high, bypass path; here both only while chain 0 is selected.
// - Clamp-float: outputs disabled, data from cells; here outputs disabled only while chain 0 is selected.
// - Bypass captures zero and ignores update.
// - SAMPLE/PRELOAD keeps cells in normal mode.
// - Restart: bypass path, pulse entering Run-Test/Idle.
package jtp_pkg;
    localparam int JTP_IR_W = 4;
    localparam int JTP_SEL_W = 5;
    localparam int JTP_ID_W = 32;
    localparam logic [3:0] JTP_IR_EXTEST = 4'h0;
    localparam logic [3:0] JTP_IR_SCAN_SEL = 4'h2;
    localparam logic [3:0] JTP_IR_INTEST = 4'hc;
    localparam logic [3:0] JTP_IR_IDCODE = 4'he;
    localparam logic [3:0] JTP_IR_BYPASS = 4'hf;
    localparam logic [3:0] JTP_IR_CLAMP = 4'h5;
    localparam logic [3:0] JTP_IR_FLOAT_ALL = 4'h7;
    localparam logic [3:0] JTP_IR_CLAMP_FLOAT = 4'h9;
    localparam logic [3:0] JTP_IR_SAMPLE = 4'h3;
    localparam logic [3:0] JTP_IR_RESTART = 4'h4;
    localparam logic [3:0] JTP_IR_CAPTURE = 4'h1;
    localparam logic [4:0] JTP_SEL_CAPTURE = 5'h10;
    localparam logic [4:0] JTP_SEL_RESET = 5'h03;
    localparam logic [4:0] JTP_SEL_CHAIN0 = 5'h00;
    // APB register map.
    localparam logic [7:0] JTP_REG_CTRL = 8'h00;
    localparam logic [7:0] JTP_REG_STATUS = 8'h04;
    localparam logic [7:0] JTP_REG_ID = 8'h08;
    localparam logic [31:0] JTP_CTRL_RESET = 32'h0000_0001;
    localparam int JTP_CTRL_BUS_OE_BIT = 0;
    localparam int JTP_ST_STATE_LSB = 0;
    localparam int JTP_ST_INSTR_LSB = 4;
    localparam int JTP_ST_CHAIN_LSB = 8;
    localparam int JTP_ST_FLOAT_BIT = 16;

    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
        ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } jtp_state_type;

    typedef enum logic [1:0] {PATH_BYPASS, PATH_ID, PATH_SELECT, PATH_CHAIN} jtp_path_type;

    function automatic logic [3:0] jtp_state_code(input jtp_state_type s);
        unique case (s)
            ST_TLR: return 4'hf;
            ST_RTI: return 4'hc;
            ST_SEL_DR: return 4'h7;
            ST_CAP_DR: return 4'h6;
            ST_SH_DR: return 4'h2;
            ST_EX1_DR: return 4'h1;
            ST_PA_DR: return 4'h3;
            ST_EX2_DR: return 4'h0;
            ST_UPD_DR: return 4'h5;
            ST_SEL_IR: return 4'h4;
            ST_CAP_IR: return 4'he;
            ST_SH_IR: return 4'ha;
            ST_EX1_IR: return 4'h9;
            ST_PA_IR: return 4'hb;
            ST_EX2_IR: return 4'h8;
            ST_UPD_IR: return 4'hd;
        endcase
    endfunction

    function automatic jtp_state_type jtp_next_state(input jtp_state_type s, input logic tms);
        unique case (s)
            ST_TLR: return tms ? ST_TLR : ST_RTI;
            ST_RTI: return tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: return tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: return tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: return tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: return tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: return tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: return tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: return tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: return tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: return tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: return tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: return tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: return tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: return tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: return tms ? ST_SEL_DR : ST_RTI;
        endcase
    endfunction

    function automatic jtp_path_type jtp_path(input logic [3:0] instr);
        unique case (instr)
            JTP_IR_EXTEST, JTP_IR_INTEST, JTP_IR_SAMPLE: return PATH_CHAIN;
            JTP_IR_SCAN_SEL: return PATH_SELECT;
            JTP_IR_IDCODE: return PATH_ID;
            default: return PATH_BYPASS;
        endcase
    endfunction
endpackage

/* logic/jtp_shreg.sv */
// Parameterised capture and shift register used for every internal serial path.
`timescale 1ns/10ps
module jtp_shreg
    import jtp_pkg::*;
#(
    parameter int W = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic capture,
    input wire logic shift,
    input wire logic sin,
    input wire logic [W-1:0] cap_val,
    output logic [W-1:0] data
);
    // A width below one leaves nothing to shift, so elaboration refuses it.
    if (W < 1) begin : g_width_check
        $error("jtp_shreg needs a width of at least one");
    end

    typedef struct packed {
        logic [W-1:0] sr;
    } jtp_shreg_type;

    jtp_shreg_type st_q;
    jtp_shreg_type st_d;
    logic [W:0] cat;

    always_comb begin
        st_d = st_q;
        cat = {sin, st_q.sr};
        if (capture) begin
            st_d.sr = cap_val;
        end else if (shift) begin
            // Shifts towards bit zero, so the least significant bit leaves first.
            st_d.sr = cat[W:1];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign data = st_q.sr;
endmodule // jtp_shreg

/* logic/jtp_tap.sv */
// Test access port controller, instruction decoder and serial path selection.
`timescale 1ns/10ps
module jtp_tap
    import jtp_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic test_logic_reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic [31:0] id_code_inputs,
    input wire logic chain_so,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic tdo,
    output logic tdo_oe,
    output logic [3:0] tap_state_code,
    output logic [3:0] instr_code,
    output logic [4:0] chain_select,
    output logic cells_test_mode,
    output logic outputs_disable,
    output logic float_indicator,
    output logic chain_capture,
    output logic chain_shift,
    output logic chain_update,
    output logic chain_si,
    output logic restart_pulse
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic tck_prev;
        jtp_state_type state;
        logic [3:0] instr;
        logic [4:0] chain;
        logic tdo;
        logic tdo_oe;
        logic [3:0] state_code;
        logic cells_test;
        logic out_off;
        logic float_ind;
        logic chain_cap;
        logic chain_sh;
        logic chain_upd;
        logic chain_tdi;
        logic restart;
    } jtp_tap_type;

    jtp_tap_type st_q;
    jtp_tap_type st_d;
    logic tap_rst_n;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic rise;
    logic fall;
    jtp_path_type path;
    logic [3:0] ir_data;
    logic [4:0] sel_data;
    logic [31:0] id_data;
    logic [0:0] byp_data;
    logic bus_oe;
    logic chain0;

    // Test reset acts without any clock; it is joined with the system reset.
    assign tap_rst_n = rstn & test_logic_reset_n;
    assign tck_s = st_q.s2[0];
    assign tms_s = st_q.s2[1];
    assign tdi_s = st_q.s2[2];
    assign rise = tck_s & ~st_q.tck_prev;
    assign fall = ~tck_s & st_q.tck_prev;
    assign path = jtp_path(st_q.instr);

    jtp_shreg #(.W(JTP_IR_W)) u_ir (
        .mclk(mclk),
        .rst_n(tap_rst_n),
        .capture(rise && (st_q.state == ST_CAP_IR)),
        .shift(rise && (st_q.state == ST_SH_IR)),
        .sin(tdi_s),
        .cap_val(JTP_IR_CAPTURE),
        .data(ir_data)
    );

    jtp_shreg #(.W(JTP_SEL_W)) u_sel (
        .mclk(mclk),
        .rst_n(tap_rst_n),
        .capture(rise && (st_q.state == ST_CAP_DR) && (path == PATH_SELECT)),
        .shift(rise && (st_q.state == ST_SH_DR) && (path == PATH_SELECT)),
        .sin(tdi_s),
        .cap_val(JTP_SEL_CAPTURE),
        .data(sel_data)
    );

    jtp_shreg #(.W(JTP_ID_W)) u_id (
        .mclk(mclk),
        .rst_n(tap_rst_n),
        .capture(rise && (st_q.state == ST_CAP_DR) && (path == PATH_ID)),
        .shift(rise && (st_q.state == ST_SH_DR) && (path == PATH_ID)),
        .sin(tdi_s),
        .cap_val(id_code_inputs),
        .data(id_data)
    );

    jtp_shreg #(.W(1)) u_byp (
        .mclk(mclk),
        .rst_n(tap_rst_n),
        .capture(rise && (st_q.state == ST_CAP_DR) && (path == PATH_BYPASS)),
        .shift(rise && (st_q.state == ST_SH_DR) && (path == PATH_BYPASS)),
        .sin(tdi_s),
        .cap_val(1'b0),
        .data(byp_data)
    );

    jtp_apb_regs u_regs (
        .mclk(mclk),
        .rstn(rstn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .stat_state(st_q.state_code),
        .stat_instr(st_q.instr),
        .stat_chain(st_q.chain),
        .stat_float(st_q.float_ind),
        .stat_id(id_code_inputs),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .bus_output_enable(bus_oe)
    );

    always_comb begin
        st_d = st_q;
        chain0 = 1'b0;
        // Pins from the host pass two flops; only the second stage is read by logic.
        st_d.s1 = {tdi, tms, tck};
        st_d.s2 = st_q.s1;
        st_d.tck_prev = tck_s;
        st_d.chain_cap = 1'b0;
        st_d.chain_sh = 1'b0;
        st_d.chain_upd = 1'b0;
        st_d.restart = 1'b0;
        if (rise) begin
            st_d.state = jtp_next_state(st_q.state, tms_s);
            if ((st_d.state == ST_RTI) && (st_q.state != ST_RTI) &&
                (st_q.instr == JTP_IR_RESTART)) begin
                st_d.restart = 1'b1;
            end
            if (path == PATH_CHAIN) begin
                st_d.chain_cap = (st_q.state == ST_CAP_DR);
                st_d.chain_sh = (st_q.state == ST_SH_DR);
                st_d.chain_tdi = tdi_s;
            end
        end
        if (fall) begin
            if (st_q.state == ST_UPD_IR) begin
                st_d.instr = ir_data;
            end
            if ((st_q.state == ST_UPD_DR) && (path == PATH_SELECT)) begin
                st_d.chain = sel_data;
            end
            // Bypass and identification paths have no update action.
            if ((st_q.state == ST_UPD_DR) && (path == PATH_CHAIN)) begin
                st_d.chain_upd = 1'b1;
            end
            // Data out moves only on the falling edge so the host can sample it on the rising one.
            st_d.tdo_oe = (st_q.state == ST_SH_IR) || (st_q.state == ST_SH_DR);
            if (st_q.state == ST_SH_IR) begin
                st_d.tdo = ir_data[0];
            end else if (st_q.state == ST_SH_DR) begin
                unique case (path)
                    PATH_BYPASS: st_d.tdo = byp_data[0];
                    PATH_ID: st_d.tdo = id_data[0];
                    PATH_SELECT: st_d.tdo = sel_data[0];
                    PATH_CHAIN: st_d.tdo = chain_so;
                endcase
            end
        end
        // Holding Test-Logic-Reset has the same effect as the reset pin.
        if (st_q.state == ST_TLR) begin
            st_d.instr = JTP_IR_IDCODE;
            st_d.chain = JTP_SEL_RESET;
        end
        chain0 = (st_d.chain == JTP_SEL_CHAIN0);
        st_d.state_code = jtp_state_code(st_d.state);
        // Clamp drives outputs from chain cells; sample, identification and bypass stay normal.
        st_d.cells_test = (st_d.instr == JTP_IR_EXTEST) || (st_d.instr == JTP_IR_INTEST) ||
                          (st_d.instr == JTP_IR_CLAMP) ||
                          (st_d.instr == JTP_IR_CLAMP_FLOAT);
        st_d.float_ind = (st_d.instr == JTP_IR_FLOAT_ALL) && chain0;
        st_d.out_off = st_d.float_ind || !bus_oe ||
                       ((st_d.instr == JTP_IR_CLAMP_FLOAT) && chain0);
    end

    always_ff @(posedge mclk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            st_q <= '{s1: '0, s2: '0, tck_prev: 1'b0, state: ST_TLR, instr: JTP_IR_IDCODE,
                      chain: JTP_SEL_RESET, tdo: 1'b0, tdo_oe: 1'b0, state_code: 4'hf,
                      cells_test: 1'b0, out_off: 1'b0, float_ind: 1'b0, chain_cap: 1'b0,
                      chain_sh: 1'b0, chain_upd: 1'b0, chain_tdi: 1'b0, restart: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign tdo = st_q.tdo;
    assign tdo_oe = st_q.tdo_oe;
    assign tap_state_code = st_q.state_code;
    assign instr_code = st_q.instr;
    assign chain_select = st_q.chain;
    assign cells_test_mode = st_q.cells_test;
    assign outputs_disable = st_q.out_off;
    assign float_indicator = st_q.float_ind;
    assign chain_capture = st_q.chain_cap;
    assign chain_shift = st_q.chain_sh;
    assign chain_update = st_q.chain_upd;
    assign chain_si = st_q.chain_tdi;
    assign restart_pulse = st_q.restart;

    chk_state_out: assert property (@(posedge mclk) disable iff (!tap_rst_n)
        tap_state_code == jtp_state_code(st_q.state))
        else $error("state output does not match controller state");

    chk_trst_async: assert property (@(posedge mclk) disable iff (!rstn)
        !test_logic_reset_n |-> (st_q.state == ST_TLR) && !st_q.cells_test)
        else $error("test reset did not hold Test-Logic-Reset");

    chk_reset_idcode: assert property (@(posedge mclk) disable iff (!tap_rst_n)
        (st_q.state == ST_TLR) |=> (st_q.instr == JTP_IR_IDCODE) && !st_q.cells_test)
        else $error("identification instruction not current after reset");

    chk_ir_capture: assert property (@(posedge mclk) disable iff (!tap_rst_n)
        (rise && (st_q.state == ST_CAP_IR)) |=> (ir_data == JTP_IR_CAPTURE))
        else $error("instruction register did not capture 0001");

    chk_sel_capture: assert property (@(posedge mclk) disable iff (!tap_rst_n)
        (rise && (st_q.state == ST_CAP_DR) && (path == PATH_SELECT))
        |=> (sel_data == JTP_SEL_CAPTURE))
        else $error("chain select register did not capture 10000");

    chk_byp_zero: assert property (@(posedge mclk) disable iff (!tap_rst_n)
        (rise && (st_q.state == ST_CAP_DR) && (path == PATH_BYPASS)) |=> (byp_data == 1'b0))
        else $error("bypass register did not capture zero");

    chk_id_capture: assert property (@(posedge mclk) disable iff (!tap_rst_n)
        (rise && (st_q.state == ST_CAP_DR) && (path == PATH_ID))
        |=> (id_data == $past(id_code_inputs)))
        else $error("identification register did not load its inputs");

    chk_tdo_fall: assert property (@(posedge mclk) disable iff (!tap_rst_n)
        $changed(tdo) |-> $past(fall))
        else $error("data out changed away from a falling clock edge");

    chk_chain_reset: assert property (@(posedge mclk) disable iff (!tap_rst_n)
        (st_q.state == ST_TLR) |=> (chain_select == JTP_SEL_RESET))
        else $error("chain 3 not selected after reset");

    chk_float_all: assert property (@(posedge mclk) disable iff (!tap_rst_n)
        ((st_q.instr == JTP_IR_FLOAT_ALL) && (st_q.chain == JTP_SEL_CHAIN0))
        |-> float_indicator && outputs_disable)
        else $error("float instruction did not float the outputs");

    chk_instr_update: assert property (@(posedge mclk) disable iff (!tap_rst_n)
        $changed(st_q.instr) |-> ($past(fall) && ($past(st_q.state) == ST_UPD_IR)) ||
        ($past(st_q.state) == ST_TLR))
        else $error("instruction changed outside Update-IR");

    chk_restart_pulse: assert property (@(posedge mclk) disable iff (!tap_rst_n)
        restart_pulse |-> (st_q.state == ST_RTI) && ($past(st_q.state) != ST_RTI) ##1 !restart_pulse)
        else $error("restart pulse not tied to entering Run-Test/Idle");

    cov_id_shift: cover property (@(posedge mclk) disable iff (!tap_rst_n)
        (st_q.state == ST_SH_DR) && (path == PATH_ID) && fall);

    cov_chain_sel: cover property (@(posedge mclk) disable iff (!tap_rst_n)
        fall && (st_q.state == ST_UPD_DR) && (path == PATH_SELECT));

    cov_float: cover property (@(posedge mclk) disable iff (!tap_rst_n) $rose(float_indicator));

    cov_restart: cover property (@(posedge mclk) disable iff (!tap_rst_n) restart_pulse);
endmodule // jtp_tap
